// ==== design/mcr_pkg.sv ====
// Package: register map, reset values and carrier types of the metering config slice
package mcr_pkg;
    // Register indices as printed; byte address is four times the index
    localparam logic [15:0] IDX_LAST_DATA   = 16'hE5FF;
    localparam logic [15:0] IDX_PEAK_PHASE  = 16'hE600;
    localparam logic [15:0] IDX_DELAY_FIRST = 16'hE601;
    localparam logic [15:0] IDX_DELAY_SECND = 16'hE602;
    localparam logic [15:0] IDX_DELAY_THIRD = 16'hE603;
    localparam logic [15:0] IDX_RSV_A_LO    = 16'hE604;
    localparam logic [15:0] IDX_RSV_A_HI    = 16'hE606;
    localparam logic [15:0] IDX_LINE_PERIOD = 16'hE607;
    localparam logic [15:0] IDX_NO_LOAD     = 16'hE608;
    localparam logic [15:0] IDX_RSV_B_LO    = 16'hE609;
    localparam logic [15:0] IDX_RSV_B_HI    = 16'hE60B;
    localparam logic [15:0] IDX_LINE_CYC    = 16'hE60C;
    localparam logic [15:0] IDX_ZX_TIMEOUT  = 16'hE60D;
    localparam logic [15:0] IDX_COMP_CTRL   = 16'hE60E;
    localparam logic [15:0] IDX_GAIN_SEL    = 16'hE60F;
    localparam logic [15:0] IDX_PULSE_CFG   = 16'hE610;
    localparam logic [15:0] IDX_PULSE_ONE   = 16'hE611;
    localparam logic [15:0] IDX_PULSE_TWO   = 16'hE612;
    localparam logic [15:0] IDX_PULSE_THREE = 16'hE613;
    localparam logic [15:0] IDX_ANGLE_TRIM  = 16'hE614;
    // Reset values
    localparam logic [15:0] RST_LINE_CYC    = 16'hFFFF;
    localparam logic [15:0] RST_ZX_TIMEOUT  = 16'hFFFF;
    localparam logic [15:0] RST_COMP_CTRL   = 16'h01FF;
    localparam logic [15:0] RST_GAIN_SEL    = 16'h0000;
    localparam logic [15:0] RST_PULSE_CFG   = 16'h0E88;
    localparam logic [15:0] RST_PULSE_DIV   = 16'h0000;
    localparam logic [9:0]  RST_ANGLE_TRIM  = 10'h000;
    // Field layout of the angle trim: 10-bit signed in a 16-bit frame
    localparam int          TRIM_WIDTH      = 10;
    localparam int          TRIM_SIGN_POS   = 9;
    // AHB transfer type and size codes
    localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
    localparam logic [2:0]  HSIZE_WORD      = 3'h2;

    // Bus-phase states, Gray along idle -> write -> read
    typedef enum logic [1:0] {
        MCR_IDLE  = 2'h0,
        MCR_WRITE = 2'h1,
        MCR_READ  = 2'h3
    } mcr_phase_type;

    // Measurement values handed in by the datapath
    typedef struct packed {
        logic [15:0] peak_phase;
        logic [15:0] delay_first;
        logic [15:0] delay_second;
        logic [15:0] delay_third;
        logic [15:0] line_period;
        logic [15:0] no_load;
    } mcr_meas_type;

    // Configuration values presented to the datapath
    typedef struct packed {
        logic [15:0] line_cycle_count;
        logic [15:0] zero_cross_timeout;
        logic [15:0] computation_control;
        logic [15:0] input_gain_select;
        logic [15:0] pulse_output_config;
        logic [15:0] pulse_one_divider;
        logic [15:0] pulse_two_divider;
        logic [15:0] pulse_three_divider;
        logic [9:0]  phase_a_angle_trim;
    } mcr_cfg_type;

    // Whole module state
    typedef struct packed {
        mcr_phase_type phase;
        logic [15:0]   index;
        logic          hreadyout;
        logic [31:0]   hrdata;
        logic [31:0]   last_data;
        mcr_meas_type  meas;
        mcr_cfg_type   cfg;
    } mcr_state_type;
endpackage : mcr_pkg

// ==== design/mcr_regs.sv ====
// Metering configuration register slice behind an AHB-Lite slave
//
// The AHB-Lite slave port was decided locally.
`timescale 1ns/1ps

// Contract
// - Capture each word transfer's data, read-only
// - Phase A trim: 10-bit signed, zero reset
// - Peak phase status read-only at E600
// - Three read-only phase delay registers
// - Line period read-only at E607
// - No-load status read-only at E608
// - Line cycle count, resets all ones
// - Zero-cross timeout, resets all ones
// - Computation control resets to 01FF
// - Gain select resets to zero
// - Pulse output config resets to 0E88
module mcr_regs (
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic                      hreadyout,
    output logic                      hresp,
    output logic [31:0]               hrdata,
    input  wire mcr_pkg::mcr_meas_type meas_in,
    output mcr_pkg::mcr_cfg_type      cfg_out
);

    // Registered state and its next value
    mcr_pkg::mcr_state_type st;
    mcr_pkg::mcr_state_type next_st;

    // Read mux over the word index
    function automatic logic [31:0] read_word(
        input logic [15:0]           idx,
        input mcr_pkg::mcr_state_type s
    );
        logic [31:0] w;
        w = 32'h0000_0000;
        case (idx)
            mcr_pkg::IDX_LAST_DATA:   w = s.last_data;
            mcr_pkg::IDX_PEAK_PHASE:  w = {16'h0000, s.meas.peak_phase};
            mcr_pkg::IDX_DELAY_FIRST: w = {16'h0000, s.meas.delay_first};
            mcr_pkg::IDX_DELAY_SECND: w = {16'h0000, s.meas.delay_second};
            mcr_pkg::IDX_DELAY_THIRD: w = {16'h0000, s.meas.delay_third};
            mcr_pkg::IDX_LINE_PERIOD: w = {16'h0000, s.meas.line_period};
            mcr_pkg::IDX_NO_LOAD:     w = {16'h0000, s.meas.no_load};
            mcr_pkg::IDX_LINE_CYC:    w = {16'h0000, s.cfg.line_cycle_count};
            mcr_pkg::IDX_ZX_TIMEOUT:  w = {16'h0000, s.cfg.zero_cross_timeout};
            mcr_pkg::IDX_COMP_CTRL:   w = {16'h0000, s.cfg.computation_control};
            mcr_pkg::IDX_GAIN_SEL:    w = {16'h0000, s.cfg.input_gain_select};
            mcr_pkg::IDX_PULSE_CFG:   w = {16'h0000, s.cfg.pulse_output_config};
            mcr_pkg::IDX_PULSE_ONE:   w = {16'h0000, s.cfg.pulse_one_divider};
            mcr_pkg::IDX_PULSE_TWO:   w = {16'h0000, s.cfg.pulse_two_divider};
            mcr_pkg::IDX_PULSE_THREE: w = {16'h0000, s.cfg.pulse_three_divider};
            // Zero-padded into the 16-bit frame, zero above
            mcr_pkg::IDX_ANGLE_TRIM:  w = 32'(s.cfg.phase_a_angle_trim);
            default:                  w = 32'h0000_0000;                 // Unmapped reads zero
        endcase
        return w;
    endfunction : read_word

    // Address-phase acceptance
    logic        take;
    logic [15:0] take_index;
    assign take       = hsel && hready && (htrans == mcr_pkg::HTRANS_NONSEQ);
    assign take_index = haddr[17:2];

    // Next-state logic: address phase, data phase, captures
    always_comb begin
        next_st           = st;
        next_st.meas      = meas_in;          // Measurement values tracked every cycle
        next_st.hreadyout = 1'b1;             // Zero-wait slave
        // Data phase of a write: capture the data, store into RW registers only
        if (st.phase == mcr_pkg::MCR_WRITE) begin
            next_st.last_data = hwdata;
            case (st.index)
                mcr_pkg::IDX_LINE_CYC:    next_st.cfg.line_cycle_count    = hwdata[15:0];
                mcr_pkg::IDX_ZX_TIMEOUT:  next_st.cfg.zero_cross_timeout  = hwdata[15:0];
                mcr_pkg::IDX_COMP_CTRL:   next_st.cfg.computation_control = hwdata[15:0];
                mcr_pkg::IDX_GAIN_SEL:    next_st.cfg.input_gain_select   = hwdata[15:0];
                mcr_pkg::IDX_PULSE_CFG:   next_st.cfg.pulse_output_config = hwdata[15:0];
                mcr_pkg::IDX_PULSE_ONE:   next_st.cfg.pulse_one_divider   = hwdata[15:0];
                mcr_pkg::IDX_PULSE_TWO:   next_st.cfg.pulse_two_divider   = hwdata[15:0];
                mcr_pkg::IDX_PULSE_THREE: next_st.cfg.pulse_three_divider = hwdata[15:0];
                mcr_pkg::IDX_ANGLE_TRIM:
                    next_st.cfg.phase_a_angle_trim = hwdata[mcr_pkg::TRIM_WIDTH-1:0];
                // Read-only, reserved and unmapped words keep their contents
                default: next_st.cfg = st.cfg;
            endcase
        end
        // Data phase of a read: the word on hrdata is the transferred data
        if (st.phase == mcr_pkg::MCR_READ) begin
            next_st.last_data = st.hrdata;
        end
        // Address phase
        next_st.phase = mcr_pkg::MCR_IDLE;
        if (take) begin
            next_st.index = take_index;
            if (hwrite) begin
                next_st.phase = mcr_pkg::MCR_WRITE;
            end else begin
                next_st.phase  = mcr_pkg::MCR_READ;
                next_st.hrdata = read_word(take_index, st);
            end
        end
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st                             <= '0;
            st.phase                       <= mcr_pkg::MCR_IDLE;
            st.hreadyout                   <= 1'b1;
            st.cfg.line_cycle_count        <= mcr_pkg::RST_LINE_CYC;
            st.cfg.zero_cross_timeout      <= mcr_pkg::RST_ZX_TIMEOUT;
            st.cfg.computation_control     <= mcr_pkg::RST_COMP_CTRL;
            st.cfg.input_gain_select       <= mcr_pkg::RST_GAIN_SEL;
            st.cfg.pulse_output_config     <= mcr_pkg::RST_PULSE_CFG;
            st.cfg.pulse_one_divider       <= mcr_pkg::RST_PULSE_DIV;
            st.cfg.pulse_two_divider       <= mcr_pkg::RST_PULSE_DIV;
            st.cfg.pulse_three_divider     <= mcr_pkg::RST_PULSE_DIV;
            st.cfg.phase_a_angle_trim      <= mcr_pkg::RST_ANGLE_TRIM;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from flip-flops; response always OKAY
    assign hreadyout = st.hreadyout;
    assign hrdata    = st.hrdata;
    assign hresp     = 1'b0;
    assign cfg_out   = st.cfg;

    // Assertions
    last_write_cap_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (take && hwrite) ##1 1'b1 |=> (st.last_data == $past(hwdata)))
        else $error("capture register missed write data");
    last_read_cap_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (take && !hwrite) |=> ##1 (st.last_data == $past(hrdata)))
        else $error("capture register missed read data");
    ro_write_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (take && hwrite && (take_index < mcr_pkg::IDX_LINE_CYC)) |=> ##1 $stable(st.cfg))
        else $error("write to read-only word changed configuration");
    trim_sign_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (take && !hwrite && (take_index == mcr_pkg::IDX_ANGLE_TRIM))
        |=> (hrdata[31:10] == 22'h000000) && (hrdata[9:0] == $past(cfg_out.phase_a_angle_trim)))
        else $error("angle trim frame not zero padded");
    peak_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (take && !hwrite && (take_index == mcr_pkg::IDX_PEAK_PHASE))
        |=> (hrdata == {16'h0000, $past(st.meas.peak_phase)}))
        else $error("peak phase read wrong");
    delay_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (take && !hwrite && (take_index == mcr_pkg::IDX_DELAY_THIRD))
        |=> (hrdata == {16'h0000, $past(st.meas.delay_third)}))
        else $error("third delay read wrong");
    period_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (take && !hwrite && (take_index == mcr_pkg::IDX_LINE_PERIOD))
        |=> (hrdata == {16'h0000, $past(st.meas.line_period)}))
        else $error("line period read wrong");
    noload_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (take && !hwrite && (take_index == mcr_pkg::IDX_NO_LOAD))
        |=> (hrdata == {16'h0000, $past(st.meas.no_load)}))
        else $error("no-load read wrong");
    line_cycle_count_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (take && hwrite && (take_index == mcr_pkg::IDX_LINE_CYC))
        |=> ##1 (cfg_out.line_cycle_count == $past(hwdata[15:0])))
        else $error("line cycle count not written");
    ready_always_a: assert property (@(posedge hclk) disable iff (!hresetn)
        hreadyout && !hresp)
        else $error("slave stalled or errored");

    // Write path of the zero-cross timeout word
    zx_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (take && hwrite && (take_index == mcr_pkg::IDX_ZX_TIMEOUT))
        |=> ##1 (cfg_out.zero_cross_timeout == $past(hwdata[15:0])))
        else $error("zero-cross timeout not written");

    // Write path of the computation control word
    comp_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (take && hwrite && (take_index == mcr_pkg::IDX_COMP_CTRL))
        |=> ##1 (cfg_out.computation_control == $past(hwdata[15:0])))
        else $error("computation control not written");

    // Write path of the gain select word
    gain_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (take && hwrite && (take_index == mcr_pkg::IDX_GAIN_SEL))
        |=> ##1 (cfg_out.input_gain_select == $past(hwdata[15:0])))
        else $error("gain select not written");

    // Write path of the pulse output configuration
    pulse_cfg_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (take && hwrite && (take_index == mcr_pkg::IDX_PULSE_CFG))
        |=> ##1 (cfg_out.pulse_output_config == $past(hwdata[15:0])))
        else $error("pulse output config not written");

    // Write paths of the three pulse dividers
    div_one_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (take && hwrite && (take_index == mcr_pkg::IDX_PULSE_ONE))
        |=> ##1 (cfg_out.pulse_one_divider == $past(hwdata[15:0])))
        else $error("first pulse divider not written");
    div_two_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (take && hwrite && (take_index == mcr_pkg::IDX_PULSE_TWO))
        |=> ##1 (cfg_out.pulse_two_divider == $past(hwdata[15:0])))
        else $error("second pulse divider not written");
    div_three_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (take && hwrite && (take_index == mcr_pkg::IDX_PULSE_THREE))
        |=> ##1 (cfg_out.pulse_three_divider == $past(hwdata[15:0])))
        else $error("third pulse divider not written");

    // Write path of the angle trim: low ten bits kept
    trim_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (take && hwrite && (take_index == mcr_pkg::IDX_ANGLE_TRIM))
        |=> ##1 (cfg_out.phase_a_angle_trim == $past(hwdata[9:0])))
        else $error("angle trim not written");

    // Read paths of the first two delay words
    delay_one_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (take && !hwrite && (take_index == mcr_pkg::IDX_DELAY_FIRST))
        |=> (hrdata == {16'h0000, $past(st.meas.delay_first)}))
        else $error("first delay read wrong");
    delay_two_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (take && !hwrite && (take_index == mcr_pkg::IDX_DELAY_SECND))
        |=> (hrdata == {16'h0000, $past(st.meas.delay_second)}))
        else $error("second delay read wrong");

    // Capture register reads back its value before the transfer
    cap_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (take && !hwrite && (take_index == mcr_pkg::IDX_LAST_DATA))
        |=> (hrdata == $past(st.last_data)))
        else $error("capture register read wrong");

    // Read data stands until the next read is taken
    rdata_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !(take && !hwrite) |=> $stable(hrdata))
        else $error("read data moved without a read");

    // Configuration moves only in a write data phase
    cfg_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (st.phase != mcr_pkg::MCR_WRITE) |=> $stable(cfg_out))
        else $error("configuration moved without a write");

    // Cover the main scenarios
    cov_trim_c: cover property (@(posedge hclk) disable iff (!hresetn)
        take && !hwrite && (take_index == mcr_pkg::IDX_ANGLE_TRIM));
    cov_ro_write_c: cover property (@(posedge hclk) disable iff (!hresetn)
        take && hwrite && (take_index == mcr_pkg::IDX_NO_LOAD));
    cov_write_c: cover property (@(posedge hclk) disable iff (!hresetn)
        take && hwrite && (take_index == mcr_pkg::IDX_PULSE_CFG));
    cov_read_c: cover property (@(posedge hclk) disable iff (!hresetn)
        take && !hwrite && (take_index == mcr_pkg::IDX_LAST_DATA));
    cov_b2b_c: cover property (@(posedge hclk) disable iff (!hresetn)
        (take && hwrite) ##1 (take && !hwrite));

endmodule : mcr_regs

// ==== test/mcr_host.sv ====
// Host model: single-word AHB-Lite master for the register slice
`timescale 1ns/1ps
module mcr_host (
    input  wire logic        hclk,
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata
);
    // Idle bus at time zero
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h0;
        hwdata = 32'h0;
    end
    // One word transfer: address phase, then data phase, each held until hready
    task automatic xfer(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
                        output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {14'h0, idx, 2'h0};
        htrans <= mcr_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        hsize <= mcr_pkg::HSIZE_WORD;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        // Address released: show the inverse, never a stale copy
        hsel <= 1'b0;
        htrans <= 2'h0;
        haddr <= ~haddr;
        hwdata <= wd;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd = hrdata;
        hwdata <= ~wd;
    endtask : xfer
endmodule : mcr_host

// ==== test/mcr_regs_tb.sv ====
// Testbench: reset values, read-back, read-only and capture checks of the slice
`timescale 1ns/1ps
module mcr_regs_tb;
    logic                  hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0]           haddr, hwdata, hrdata, rd, wd, cap;
    logic [1:0]            htrans;
    logic [2:0]            hsize;
    mcr_pkg::mcr_meas_type meas_in;
    mcr_pkg::mcr_cfg_type  cfg_out;
    logic [15:0]           mdl [9];
    logic [15:0]           ro_idx [6];
    int                    fail_count, check_count, seed, i;
    // Clock of 10 ns
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    mcr_regs dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .meas_in(meas_in), .cfg_out(cfg_out));
    mcr_host host (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata));
    // Compare and count
    task automatic check(input logic [159:0] seen, input logic [159:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // Verdict and end of run
    task automatic wrap_up;
        $display("checks=%0d mismatches=%0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : wrap_up
    // Read image of a config word: trim is zero-padded above bit 9
    function automatic logic [31:0] fmt(int k, logic [15:0] v);
        return (k == 8) ? {22'h0, v[9:0]} : {16'h0, v};
    endfunction : fmt
    // Expected config outputs from the model
    function automatic mcr_pkg::mcr_cfg_type cfg_exp();
        return {mdl[0], mdl[1], mdl[2], mdl[3], mdl[4], mdl[5], mdl[6], mdl[7], mdl[8][9:0]};
    endfunction : cfg_exp
    // Transfer, then read the capture register and expect the moved word
    task automatic rw(input logic wr, input logic [15:0] idx, input logic [31:0] d);
        host.xfer(wr, idx, d, rd);
        host.xfer(1'b0, mcr_pkg::IDX_LAST_DATA, 32'h0, cap);
        check(160'(cap), 160'(wr ? d : rd));
        check(160'({hreadyout, hresp}), 160'(2'b10)); // Ready, OKAY
    endtask : rw
    // Main sequence
    initial begin
        seed = 28;
        fail_count = 0;
        check_count = 0;
        hresetn = 1'b0;
        meas_in = '0;
        mdl = '{16'hFFFF, 16'hFFFF, 16'h01FF, 16'h0000, 16'h0E88, 16'h0, 16'h0, 16'h0, 16'h0};
        ro_idx = '{16'hE600, 16'hE601, 16'hE602, 16'hE603, 16'hE607, 16'hE608};
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        // Reset values seen on outputs and by reads
        @(posedge hclk);
        check(160'(cfg_out), 160'(cfg_exp()));
        for (i = 0; i < 9; i++) begin
            rw(1'b0, mcr_pkg::IDX_LINE_CYC + 16'(i), 32'h0);
            check(160'(rd), 160'(fmt(i, mdl[i])));
        end
        $display("test reset values done");
        // Random writes, trim sign corners, read-back
        for (i = 0; i < 27; i++) begin
            wd = $random(seed);
            if (i == 8) wd = 32'hFFFF_FE00;
            if (i == 17) wd = 32'h0000_01FF;
            rw(1'b1, mcr_pkg::IDX_LINE_CYC + 16'(i % 9), wd);
            mdl[i % 9] = (i % 9 == 8) ? {6'h0, wd[9:0]} : wd[15:0];
            rw(1'b0, mcr_pkg::IDX_LINE_CYC + 16'(i % 9), 32'h0);
            check(160'(rd), 160'(fmt(i % 9, mdl[i % 9])));
            check(160'(cfg_out), 160'(cfg_exp()));
        end
        $display("test write read-back done");
        // Read-only measurement words, writes to them ignored
        meas_in <= {$random(seed), $random(seed), $random(seed)};
        repeat (3) @(posedge hclk);
        for (i = 0; i < 6; i++) begin
            rw(1'b0, ro_idx[i], 32'h0);
            check(160'(rd), 160'({16'h0, meas_in[16 * (5 - i) +: 16]}));
            rw(1'b1, ro_idx[i], $random(seed));
            rw(1'b0, ro_idx[i], 32'h0);
            check(160'(rd), 160'({16'h0, meas_in[16 * (5 - i) +: 16]}));
        end
        rw(1'b1, mcr_pkg::IDX_LAST_DATA, 32'hA5C3_0F96);
        check(160'(cfg_out), 160'(cfg_exp()));
        $display("test read-only words done");
        // Holes and unmapped words are only read, never written
        rw(1'b0, mcr_pkg::IDX_RSV_A_LO, 32'h0);
        check(160'(rd), 160'(32'h0));
        rw(1'b0, 16'hE615, 32'h0);
        check(160'(rd), 160'(32'h0));
        $display("test unmapped reads done");
        wrap_up;
    end
    // Watchdog against a hung handshake
    initial begin
        #200000;
        fail_count++;
        wrap_up;
    end
endmodule : mcr_regs_tb
